// ==== core/srpp_checker.sv ====
// Memory protection checker: range sets, page permissions, level limits
// --------------------------------------------------------------------------
// Summary of operation
// - Both address spaces are 4 GB in sixteen 256 MB segments.
// - Segment number is address bits 31 to 28.
// - Upper-half addresses pass unchanged as physical, in either mode.
// - Lower half is direct in physical mode, page-translated in virtual.
// - Every violating access raises a trap toward the handler routine.
// - Violations drive indication signals to the debug unit.
// - Direct addresses get range checks on read, write and fetch.
// - Four register sets; protection_set_select picks the active one.
// - Each set has a data part for loads/stores, code part for fetches.
// - Data part holds up to four ranges, each with own mode.
// - Code part holds up to two ranges, each with own mode.
// - Ranges bounded by register pairs; a mode register per part.
// - Translated addresses are checked with page table entry bits.
// - Fetch from translated page needs page_execute_permit.
// - Write to translated page needs the page write permit.
// - Read from translated page needs page_read_permit.
// - Virtual mode: user-0 access to upper half is rejected.
// - Physical mode: user-0 rejected only in segments 14 and 15.
// - Such user-0 accesses raise the virtual address protection trap.
// --------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module srpp_checker
   import srpp_pkg::*;
(
   input  wire logic                  ref_clk_i,
   input  wire logic                  nrst_i,
   input  wire logic                  ce_i,
   // Avalon-MM slave, word address
   input  wire logic [7:0]            avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [31:0]           avs_writedata_i,
   output logic      [31:0]           avs_readdata_o,
   output logic                       avs_waitrequest_o,
   // Access request from the core
   input  wire logic                  req_valid_i,
   input  wire logic [ADDR_W-1:0]     req_addr_i,
   input  wire logic [1:0]            req_kind_i,
   input  wire logic [1:0]            req_priv_i,
   input  wire logic                  virt_mode_i,
   input  wire logic [1:0]            protection_set_select_i,
   input  wire logic [FRAME_W-1:0]    page_table_entry_frame_i,
   input  wire logic                  page_execute_permit_i,
   input  wire logic                  page_write_permit_i,
   input  wire logic                  page_read_permit_i,
   // Checked access result, one cycle after the request
   output logic                       rsp_valid_o,
   output logic                       rsp_grant_o,
   output logic      [ADDR_W-1:0]     rsp_phys_addr_o,
   output logic                       trap_o,
   output logic      [2:0]            trap_cause_o,
   output logic                       virtual_address_protection_trap_o,
   // Debug unit indication
   output logic                       dbg_viol_o,
   output logic      [ADDR_W-1:0]     dbg_viol_addr_o,
   output logic      [1:0]            dbg_viol_kind_o
);
   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   // Lower bound inclusive, upper bound exclusive; empty when hi <= lo
   function automatic logic in_range(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
      in_range = (a >= lo) && (a < hi);
   endfunction : in_range

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [31:0]        dlo_q   [NSETS][NDRANGE];
   logic [31:0]        dhi_q   [NSETS][NDRANGE];
   logic [31:0]        clo_q   [NSETS][NCRANGE];
   logic [31:0]        chi_q   [NSETS][NCRANGE];
   logic [DMODE_W-1:0] dmode_q [NSETS];
   logic [NCRANGE-1:0] cmode_q [NSETS];
   logic               en_q;
   logic [31:0]        vaddr_q;
   logic [2:0]         vcause_q;
   logic [VCNT_W-1:0]  vcnt_q;
   logic [31:0]        rdata_q;
   logic               rd_wait_q;

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wire [9:0] bus_byte  = {avs_address_i, 2'b00};
   wire       in_sets   = bus_byte < (SET_STRIDE * 10'(NSETS));
   wire [1:0] bus_set   = bus_byte[7:6];
   wire [5:0] bus_ofs   = bus_byte[5:0];
   wire       sel_dlo   = in_sets && bus_ofs < OFS_CLO && !bus_ofs[2];
   wire       sel_dhi   = in_sets && bus_ofs < OFS_CLO && bus_ofs[2];
   wire       sel_clo   = in_sets && bus_ofs >= OFS_CLO &&
                          bus_ofs < OFS_DMODE && !bus_ofs[2];
   wire       sel_chi   = in_sets && bus_ofs >= OFS_CLO &&
                          bus_ofs < OFS_DMODE && bus_ofs[2];
   wire       sel_dmode = in_sets && bus_ofs == OFS_DMODE;
   wire       sel_cmode = in_sets && bus_ofs == OFS_CMODE;
   wire       sel_ctrl  = bus_byte == OFS_CTRL;
   wire       sel_vaddr = bus_byte == OFS_VADDR;
   wire       sel_vstat = bus_byte == OFS_VSTAT;
   wire [1:0] dr_idx    = bus_ofs[4:3];
   wire       cr_idx    = bus_ofs[3];
   wire       wr_en     = ce_i && avs_write_i;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_dlo)
         rd_mux = dlo_q[bus_set][dr_idx];
      else if (sel_dhi)
         rd_mux = dhi_q[bus_set][dr_idx];
      else if (sel_clo)
         rd_mux = clo_q[bus_set][cr_idx];
      else if (sel_chi)
         rd_mux = chi_q[bus_set][cr_idx];
      else if (sel_dmode)
         rd_mux = {24'h000000, dmode_q[bus_set]};
      else if (sel_cmode)
         rd_mux = {30'h00000000, cmode_q[bus_set]};
      else if (sel_ctrl)
         rd_mux = {31'h00000000, en_q};
      else if (sel_vaddr)
         rd_mux = vaddr_q;
      else if (sel_vstat)
         rd_mux = {8'h00, vcnt_q, 5'h00, vcause_q};
   end

   // Reads take one wait cycle, writes none; unmapped reads return zero
   assign avs_waitrequest_o = avs_read_i && !rd_wait_q;
   assign avs_readdata_o    = rdata_q;

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rd_wait_q <= 1'b0;
         rdata_q   <= 32'h0000_0000;
      end else if (ce_i) begin
         rd_wait_q <= avs_read_i && !rd_wait_q;
         if (avs_read_i && !rd_wait_q)
            rdata_q <= rd_mux;
      end
   end

   // ----------------------------------------------------------------------
   // Range and mode registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         for (int s = 0; s < NSETS; s++) begin
            for (int k = 0; k < NDRANGE; k++) begin
               dlo_q[s][k] <= RANGE_RST;
               dhi_q[s][k] <= RANGE_RST;
            end
            for (int k = 0; k < NCRANGE; k++) begin
               clo_q[s][k] <= RANGE_RST;
               chi_q[s][k] <= RANGE_RST;
            end
            dmode_q[s] <= 8'h00;
            cmode_q[s] <= 2'h0;
         end
         en_q <= CTRL_RST;
      end else if (wr_en) begin
         if (sel_dlo)
            dlo_q[bus_set][dr_idx] <= avs_writedata_i;
         if (sel_dhi)
            dhi_q[bus_set][dr_idx] <= avs_writedata_i;
         if (sel_clo)
            clo_q[bus_set][cr_idx] <= avs_writedata_i;
         if (sel_chi)
            chi_q[bus_set][cr_idx] <= avs_writedata_i;
         if (sel_dmode)
            dmode_q[bus_set] <= avs_writedata_i[DMODE_W-1:0];
         if (sel_cmode)
            cmode_q[bus_set] <= avs_writedata_i[NCRANGE-1:0];
         if (sel_ctrl)
            en_q <= avs_writedata_i[CTRL_EN];
      end
   end

   // ----------------------------------------------------------------------
   // Address classification and translation
   // ----------------------------------------------------------------------
   wire [3:0]  seg      = req_addr_i[SEG_MSB:SEG_LSB];
   wire        upper    = seg[3];
   wire        pte_path = virt_mode_i && !upper;
   wire [31:0] phys     = pte_path ?
                          {page_table_entry_frame_i,
                           req_addr_i[PAGE_OFS_W-1:0]} :
                          req_addr_i;
   wire        is_fetch = req_kind_i == SRPP_FETCH;
   wire        is_read  = req_kind_i == SRPP_READ;
   wire        is_write = req_kind_i == SRPP_WRITE;
   wire        user0    = req_priv_i == SRPP_USER0;

   // Level restriction: upper half in virtual mode, top two segments else
   wire        vap_hit  = user0 && (virt_mode_i ? upper :
                                    seg >= SEG_RSV_LO);

   // ----------------------------------------------------------------------
   // Range check on the active set
   // ----------------------------------------------------------------------
   wire [1:0]         aset = protection_set_select_i;
   logic [NDRANGE-1:0] d_hit;
   logic [NCRANGE-1:0] c_hit;
   always_comb begin
      for (int k = 0; k < NDRANGE; k++)
         d_hit[k] = in_range(req_addr_i, dlo_q[aset][k],
                             dhi_q[aset][k]);
      for (int k = 0; k < NCRANGE; k++)
         c_hit[k] = in_range(req_addr_i, clo_q[aset][k],
                             chi_q[aset][k]);
   end

   logic [NDRANGE-1:0] d_rd_en;
   logic [NDRANGE-1:0] d_wr_en;
   always_comb begin
      for (int k = 0; k < NDRANGE; k++) begin
         d_rd_en[k] = dmode_q[aset][2*k+DMODE_RD];
         d_wr_en[k] = dmode_q[aset][2*k+DMODE_WR];
      end
   end

   // Data part serves loads and stores, code part serves fetches
   wire rng_rd_ok = |(d_hit & d_rd_en);
   wire rng_wr_ok = |(d_hit & d_wr_en);
   wire rng_fe_ok = |(c_hit & cmode_q[aset]);
   wire rng_bad   = en_q && !pte_path &&
                    ((is_read  && !rng_rd_ok) ||
                     (is_write && !rng_wr_ok) ||
                     (is_fetch && !rng_fe_ok));

   // Page checks replace the range check on translated addresses
   wire pte_bad   = pte_path &&
                    ((is_fetch && !page_execute_permit_i) ||
                     (is_write && !page_write_permit_i)   ||
                     (is_read  && !page_read_permit_i));

   // Level trap takes priority over permission faults
   logic [2:0] cause_d;
   always_comb begin
      if (vap_hit)
         cause_d = SRPP_VAP;
      else if (pte_bad && is_fetch)
         cause_d = SRPP_PTE_FETCH;
      else if (pte_bad && is_write)
         cause_d = SRPP_PTE_WRITE;
      else if (pte_bad)
         cause_d = SRPP_PTE_READ;
      else if (rng_bad && is_fetch)
         cause_d = SRPP_RNG_FETCH;
      else if (rng_bad && is_write)
         cause_d = SRPP_RNG_WRITE;
      else if (rng_bad)
         cause_d = SRPP_RNG_READ;
      else
         cause_d = SRPP_OK;
   end
   wire viol_d = req_valid_i && cause_d != SRPP_OK;

   // ----------------------------------------------------------------------
   // Response register
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rsp_valid_o     <= 1'b0;
         rsp_grant_o     <= 1'b0;
         rsp_phys_addr_o <= 32'h0000_0000;
         trap_o          <= 1'b0;
         trap_cause_o    <= 3'h0;
         virtual_address_protection_trap_o <= 1'b0;
      end else if (ce_i) begin
         rsp_valid_o     <= req_valid_i;
         rsp_grant_o     <= req_valid_i && !viol_d;
         rsp_phys_addr_o <= viol_d ? 32'h0000_0000 : phys;
         trap_o          <= viol_d;
         trap_cause_o    <= req_valid_i ? cause_d : 3'h0;
         virtual_address_protection_trap_o <=
            req_valid_i && vap_hit;
      end
   end

   // ----------------------------------------------------------------------
   // Debug indication and violation status
   // ----------------------------------------------------------------------
   // The count saturates so a flood of faults cannot wrap back to zero
   wire vstat_clr = wr_en && sel_vstat;
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         dbg_viol_o      <= 1'b0;
         dbg_viol_addr_o <= 32'h0000_0000;
         dbg_viol_kind_o <= 2'h0;
         vaddr_q         <= 32'h0000_0000;
         vcause_q        <= 3'h0;
         vcnt_q          <= 16'h0000;
      end else if (ce_i) begin
         dbg_viol_o <= viol_d;
         if (viol_d) begin
            dbg_viol_addr_o <= req_addr_i;
            dbg_viol_kind_o <= req_kind_i;
            vaddr_q         <= req_addr_i;
            vcause_q        <= cause_d;
         end
         // A fault in the clearing cycle is still counted
         if (viol_d && vstat_clr)
            vcnt_q <= 16'h0001;
         else if (vstat_clr)
            vcnt_q <= 16'h0000;
         else if (viol_d && vcnt_q != 16'hffff)
            vcnt_q <= vcnt_q + 16'h0001;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   trap_blocks_a: assert property (
      trap_o |-> !rsp_grant_o && rsp_phys_addr_o == 32'h0000_0000)
      else $error("Trapped access was granted");
   trap_in_step_a: assert property (
      ce_i && req_valid_i |=> rsp_valid_o && (trap_o != rsp_grant_o))
      else $error("Response missing one cycle after request");
   upper_pass_a: assert property (
      ce_i && req_valid_i && req_addr_i[31] && req_priv_i != SRPP_USER0
      && !en_q |=> rsp_phys_addr_o == $past(req_addr_i))
      else $error("Upper half address was altered");
   pte_xlate_a: assert property (
      ce_i && req_valid_i && virt_mode_i && !req_addr_i[31] && !vap_hit
      && page_execute_permit_i && page_read_permit_i && page_write_permit_i
      |=> rsp_phys_addr_o[31:12] == $past(page_table_entry_frame_i)
      && rsp_grant_o)
      else $error("Translated frame not applied");
   pte_exec_a: assert property (
      ce_i && req_valid_i && pte_path && is_fetch && !page_execute_permit_i
      |=> trap_o)
      else $error("Fetch without execute permit not trapped");
   pte_write_a: assert property (
      ce_i && req_valid_i && pte_path && is_write && !page_write_permit_i
      |=> trap_o && !rsp_grant_o)
      else $error("Write without write permit not trapped");
   pte_read_a: assert property (
      ce_i && req_valid_i && pte_path && is_read && !page_read_permit_i
      |=> trap_o)
      else $error("Read without read permit not trapped");
   virt_user0_a: assert property (
      ce_i && req_valid_i && virt_mode_i && user0 && upper
      |=> virtual_address_protection_trap_o
      && trap_cause_o == SRPP_VAP)
      else $error("User-0 upper access not trapped");
   phys_user0_a: assert property (
      ce_i && req_valid_i && !virt_mode_i && user0
      |=> virtual_address_protection_trap_o ==
      ($past(req_addr_i[31:29]) == 3'h7))
      else $error("User-0 segment rule wrong in physical mode");
   range_off_a: assert property (
      ce_i && req_valid_i && !en_q && !pte_path && !vap_hit
      |=> rsp_grant_o)
      else $error("Range check active while disabled");
   // Only judged after an enabled edge, since a frozen clock holds the flag
   dbg_follow_a: assert property (
      $past(ce_i) && dbg_viol_o |-> trap_o
      && dbg_viol_addr_o == $past(req_addr_i)
      && dbg_viol_kind_o == $past(req_kind_i))
      else $error("Debug indication out of step with trap");

   vap_seen_c:   cover property (virtual_address_protection_trap_o);
   rng_fault_c:  cover property (trap_cause_o == SRPP_RNG_WRITE);
   pte_grant_c:  cover property (rsp_grant_o && $past(pte_path));
   set3_grant_c: cover property (rsp_grant_o && $past(aset) == 2'h3);

endmodule : srpp_checker
`default_nettype wire

// ==== core/srpp_pkg.sv ====
// Package: constants, encodings and register map of the protection checker
package srpp_pkg;
   // ----------------------------------------------------------------------
   // Address space and segments
   // ----------------------------------------------------------------------
   localparam int          ADDR_W      = 32;
   localparam int          SEG_MSB     = 31;
   localparam int          SEG_LSB     = 28;
   localparam int          SEG_COUNT   = 16;
   localparam logic [3:0]  SEG_RSV_LO  = 4'he;
   localparam int          PAGE_OFS_W  = 12;
   localparam int          FRAME_W     = ADDR_W - PAGE_OFS_W;
   // ----------------------------------------------------------------------
   // Protection sets
   // ----------------------------------------------------------------------
   localparam int          NSETS       = 4;
   localparam int          NDRANGE     = 4;
   localparam int          NCRANGE     = 2;
   localparam int          DMODE_W     = 2 * NDRANGE;
   localparam int          DMODE_RD    = 0;
   localparam int          DMODE_WR    = 1;
   // ----------------------------------------------------------------------
   // Register map, byte offsets; set block stride and offsets within it
   // ----------------------------------------------------------------------
   localparam logic [9:0]  SET_STRIDE  = 10'h040;
   localparam logic [5:0]  OFS_DLO     = 6'h00;
   localparam logic [5:0]  OFS_CLO     = 6'h20;
   localparam logic [5:0]  OFS_DMODE   = 6'h30;
   localparam logic [5:0]  OFS_CMODE   = 6'h34;
   localparam logic [9:0]  OFS_CTRL    = 10'h100;
   localparam logic [9:0]  OFS_VADDR   = 10'h104;
   localparam logic [9:0]  OFS_VSTAT   = 10'h108;
   localparam int          CTRL_EN     = 0;
   localparam logic        CTRL_RST    = 1'b0;
   localparam logic [31:0] RANGE_RST   = 32'h0000_0000;
   localparam int          VCNT_W      = 16;
   localparam int          VCNT_LSB    = 8;
   // ----------------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRPP_FETCH, SRPP_READ, SRPP_WRITE, SRPP_KIND_RSV
   } srpp_kind_t;
   typedef enum logic [1:0] {
      SRPP_USER0, SRPP_USER1, SRPP_SUPER, SRPP_PRIV_RSV
   } srpp_priv_t;
   typedef enum logic [2:0] {
      SRPP_OK, SRPP_RNG_FETCH, SRPP_RNG_READ, SRPP_RNG_WRITE,
      SRPP_PTE_FETCH, SRPP_PTE_READ, SRPP_PTE_WRITE, SRPP_VAP
   } srpp_cause_t;
endpackage : srpp_pkg

// ==== sim/srpp_checker_tb_top.sv ====
// Testbench: register access and access-check scenarios
`timescale 1ns/100ps
`default_nettype none
module srpp_checker_tb_top;
   import srpp_pkg::*;
   // ---------------------------------------------------------------
   // Signals and counters
   // ---------------------------------------------------------------
   logic              ref_clk_i = 1'b0, nrst_i = 1'b0;
   logic              av_rd = 1'b0, av_wr = 1'b0, av_wait;
   logic [7:0]        av_addr = 8'h00;
   logic [31:0]       av_wdata = 32'h0, av_rdata, rd;
   logic              valid, vm, rv, grant, trap, virtual_address_protection_trap, dv;
   logic [1:0]        kind, priv, pss, dkind;
   logic [2:0]        perm, cause;
   logic [19:0]       frame;
   logic [31:0]       addr, phys, daddr;
   int                num_errors = 0, checked = 0, cycles = 0;
   always #10 ref_clk_i = ~ref_clk_i;
   srpp_core_model srpp_core_model_inst (.clk_i(ref_clk_i),
      .valid_o(valid), .addr_o(addr), .kind_o(kind), .priv_o(priv),
      .virt_o(vm), .pss_o(pss), .frame_o(frame), .perm_o(perm));
   srpp_checker srpp_checker_inst (.ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i), .ce_i(1'b1), .avs_address_i(av_addr),
      .avs_read_i(av_rd), .avs_write_i(av_wr),
      .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata),
      .avs_waitrequest_o(av_wait), .req_valid_i(valid),
      .req_addr_i(addr), .req_kind_i(kind), .req_priv_i(priv),
      .virt_mode_i(vm), .protection_set_select_i(pss),
      .page_table_entry_frame_i(frame), .page_execute_permit_i(perm[2]),
      .page_write_permit_i(perm[1]), .page_read_permit_i(perm[0]),
      .rsp_valid_o(rv), .rsp_grant_o(grant), .rsp_phys_addr_o(phys),
      .trap_o(trap), .trap_cause_o(cause),
      .virtual_address_protection_trap_o(virtual_address_protection_trap), .dbg_viol_o(dv),
      .dbg_viol_addr_o(daddr), .dbg_viol_kind_o(dkind));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   // Request holds until the rising edge that sees waitrequest low
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk_i);
      {av_rd, av_wr, av_addr, av_wdata} <= {~w, w, a, d};
      do @(posedge ref_clk_i); while (av_wait !== 1'b0);
      rd = av_rdata;
      {av_rd, av_wr} <= 2'b00;
   endtask : bus
   task automatic run(logic [31:0] a, logic [1:0] k, p, logic v,
                      logic [1:0] s, logic [2:0] pm, logic g,
                      logic [31:0] ph, logic [2:0] c);
      srpp_core_model_inst.issue(a, k, p, v, s, pm);
      @(negedge ref_clk_i);
      check("rsp_valid", rv, 1);
      check("grant", grant, g);
      check("trap", trap, !g);
      check("phys", phys, g ? ph : 0);
      check("cause", cause, c);
      check("vap", virtual_address_protection_trap, c == 3'h7);
      check("dbg", dv, !g);
      if (!g) check("dbg_addr", daddr, a);
      if (!g) check("dbg_kind", dkind, k);
   endtask : run
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      bus(0, 8'h40, 0);
      check("ctrl_rst", rd, 0);
      bus(1, 8'hff, 32'hffff_ffff);
      bus(0, 8'hff, 0);
      check("unmapped", rd, 0);
   endtask : t_regs
   // Permit bits: execute 2, write 1, read 0; kinds fetch 0, read 1, write 2
   task automatic t_page();
      logic [2:0] pm;
      for (int k = 0; k < 3; k++) begin
         pm = 3'h1 << ((k + 2) % 3);
         run(32'h0abc_d678, k, 0, 1, 0, pm, 1, 32'h1234_5678, 0);
         run(32'h0abc_def4, k, 0, 1, 0, ~pm, 0, 0, 4 + k);
      end
   endtask : t_page
   task automatic t_level();
      run(32'h8000_0000, 1, 0, 1, 0, 7, 0, 0, 7);
      run(32'h8000_0000, 1, 1, 1, 0, 7, 1, 32'h8000_0000, 0);
      run(32'he000_0010, 2, 0, 0, 0, 7, 0, 0, 7);
      run(32'hd000_0010, 2, 0, 0, 0, 7, 1, 32'hd000_0010, 0);
      run(32'hf000_0004, 1, 2, 1, 0, 0, 1, 32'hf000_0004, 0);
      run(32'h1000_0040, 0, 0, 0, 0, 0, 1, 32'h1000_0040, 0);
   endtask : t_level
   task automatic t_range();
      bus(1, 8'h20, 32'h8000_0000);
      bus(1, 8'h21, 32'h8000_1000);
      bus(1, 8'h28, 32'h8000_0000);
      bus(1, 8'h29, 32'h8000_1000);
      bus(1, 8'h2c, 32'h0000_0001);
      bus(1, 8'h2d, 32'h0000_0001);
      bus(1, 8'h40, 32'h0000_0001);
      bus(1, 8'h42, 0);
      run(32'h8000_0000, 1, 2, 0, 2, 0, 1, 32'h8000_0000, 0);
      run(32'h8000_0ffc, 1, 2, 1, 2, 0, 1, 32'h8000_0ffc, 0);
      run(32'h8000_1000, 1, 2, 0, 2, 0, 0, 0, 2);
      run(32'h8000_0010, 2, 2, 0, 2, 0, 0, 0, 3);
      run(32'h8000_0010, 0, 2, 0, 2, 0, 1, 32'h8000_0010, 0);
      run(32'h8000_2000, 0, 2, 0, 2, 0, 0, 0, 1);
      run(32'h8000_3000, 3, 2, 0, 2, 0, 1, 32'h8000_3000, 0);
      run(32'h8000_0010, 1, 2, 0, 1, 0, 0, 0, 2);
      bus(0, 8'h41, 0);
      check("viol_addr", rd, 32'h8000_0010);
      bus(0, 8'h42, 0);
      check("status", rd, 32'h0000_0402);
      bus(0, 8'h21, 0);
      check("range_hi", rd, 32'h8000_1000);
   endtask : t_range
   initial begin
      repeat (10) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      t_regs();
      t_page();
      t_level();
      t_range();
      tally_and_finish();
   end
endmodule : srpp_checker_tb_top
`default_nettype wire

// ==== sim/srpp_core_model.sv ====
// Core model: issues one access at a time toward the checker
`timescale 1ns/100ps
`default_nettype none
module srpp_core_model
   import srpp_pkg::*;
#(
   parameter logic [FRAME_W-1:0] FRAME = 20'h12345
)(
   input  wire logic          clk_i,
   output logic               valid_o,
   output logic [ADDR_W-1:0]  addr_o,
   output logic [1:0]         kind_o,
   output logic [1:0]         priv_o,
   output logic               virt_o,
   output logic [1:0]         pss_o,
   output logic [FRAME_W-1:0] frame_o,
   output logic [2:0]         perm_o
);
   // ---------------------------------------------------------------
   // Request issue; released address and permit lines flip so stale values never help
   // ---------------------------------------------------------------
   assign frame_o = FRAME;
   initial begin
      {valid_o, kind_o, priv_o, virt_o, pss_o, perm_o} <= '0;
      addr_o <= '0;
   end
   task automatic issue(input logic [31:0] a, input logic [1:0] k,
                        input logic [1:0] p, input logic v,
                        input logic [1:0] s, input logic [2:0] pm);
      @(posedge clk_i);
      {valid_o, kind_o, priv_o, virt_o, pss_o} <= {1'b1, k, p, v, s};
      addr_o <= a;
      perm_o <= pm;
      @(posedge clk_i);
      valid_o <= 1'b0;
      addr_o <= ~a;
      perm_o <= ~pm;
   endtask : issue
endmodule : srpp_core_model
`default_nettype wire
